//--- bbm_core.sv
// Operation
// RL1 - Not-zero branch jumps to pc plus offset plus one when Z clear; 1/2 cycles.
// RL2 - Carry-one and lower branch on C set; carry-zero and same-or-higher on C clear.
// RL3 - Negative branch on N set, positive branch on N clear, target pc+k+1.
// RL4 - Signed ge branches when N xor V is zero, signed lt when it is one.
// RL5 - Half-carry branches test H set or clear and change no flag.
// RL6 - Transfer branches test T set or clear; one cycle untaken, two taken.
// RL7 - Overflow branches test V set or clear and alter no flag.
// RL8 - Interrupt branches test I set or clear; one or two cycles.
// RL9 - Set and clear io bit change one io bit only, no flags, two cycles.
// RL10 - Left shift moves bits up, zero into bit 0, updates Z C N V.
// RL11 - Right shift moves bits down, zero into bit 7, updates Z C N V.
// RL12 - Rotate left puts old carry in bit 0 and old bit 7 in carry.
// RL13 - Arithmetic right shift keeps the sign bit, updates Z C N V.
// RL14 - Each flag set or clear forces only its own flag, one cycle.
// RL15 - Interrupt enable sets I, interrupt disable clears I, one cycle.
// RL16 - Bit store copies a source register bit into T only.
// RL17 - Bit load writes T into a destination bit, flags unchanged.
// RL18 - Byte copy and pair copy move registers in one cycle, no flags.
// RL19 - Branch offset is a signed two's complement value.
//
// Implementation choices: the register offsets and the Avalon-MM register port.
`include "bbm_consts.svh"

module bbm_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire bbm_pkg::bbm_avs_req_s avs,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic busy,
  output logic [15:0] pc,
  output logic [7:0][7:0] io_regs
);

  logic [1:0] rst_pipe;
  logic rst_sync_n;
  bbm_pkg::bbm_core_s q;
  bbm_pkg::bbm_core_s d;
  bbm_pkg::bbm_eval_s ev;
  logic [7:0] opnd;
  logic [7:0] src;
  logic [31:0] wdat;
  logic wr_ok;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  // Signed offset added to the step of one
  function automatic logic [15:0] bbm_pc_next(input logic [15:0] cur,
                                              input logic [7:0] k,
                                              input logic taken);
    logic [15:0] step;
    step = 16'h0001;
    if (taken) begin
      step = {{8{k[7]}}, k} + 16'h0001; // [RL19]
    end
    return cur + step;
  endfunction : bbm_pc_next

  // Replace one bit of a byte
  function automatic logic [7:0] bbm_put_bit(input logic [7:0] b,
                                             input logic [2:0] idx,
                                             input logic val);
    logic [7:0] r;
    r = b;
    r[idx] = val;
    return r;
  endfunction : bbm_put_bit

  // Register view for reads and for byte-lane merging on writes
  function automatic logic [31:0] bbm_view(input bbm_pkg::bbm_core_s s,
                                           input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a[7] == `BBM_GPR_TAG) begin
      r[7:0] = s.gpr[a[6:2]];
    end else if (a[7:5] == `BBM_IO_TAG) begin
      r[7:0] = s.io[a[4:2]];
    end else begin
      case ({a[7:2], 2'h0})
        `BBM_ADDR_CMD: begin
          r[`BBM_CMD_OP] = s.op;
          r[`BBM_CMD_RD] = s.rd;
          r[`BBM_CMD_RR] = s.rr;
          r[`BBM_CMD_BIT] = s.bsel;
        end
        `BBM_ADDR_OFFSET: r[7:0] = s.koff;
        `BBM_ADDR_PC: r[15:0] = s.pc;
        `BBM_ADDR_FLAGS: r[7:0] = s.flags;
        `BBM_ADDR_STATUS: r[2:0] = {s.st != bbm_pkg::BBM_ST_IDLE, s.last_cyc};
        default: r = 32'h0000_0000;
      endcase
    end
    return r;
  endfunction : bbm_view

  bbm_eval u_eval (
    .op(q.op),
    .flags(q.flags),
    .opnd(opnd),
    .ev(ev)
  );

  assign opnd = q.gpr[q.rd];
  assign src = q.gpr[q.rr];
  assign busy = (q.st != bbm_pkg::BBM_ST_IDLE);
  // Writes stall while an instruction runs so software never races the core
  assign wr_ok = avs.write && !busy;
  // Reads always take two cycles so readdata comes from a flop
  assign waitrequest = (avs.read && !q.rd_done) || (avs.write && busy);
  assign wdat = (bbm_view(q, avs.address) & ~{{8{avs.byteenable[3]}},
                {8{avs.byteenable[2]}}, {8{avs.byteenable[1]}},
                {8{avs.byteenable[0]}}})
              | (avs.writedata & {{8{avs.byteenable[3]}},
                {8{avs.byteenable[2]}}, {8{avs.byteenable[1]}},
                {8{avs.byteenable[0]}}});
  assign readdata = q.rdata;
  assign pc = q.pc;
  assign io_regs = q.io;

  // Next state: bus slave, then the execution sequence
  always_comb begin
    d = q;
    d.rd_done = 1'b0;
    if (avs.read && !q.rd_done) begin
      d.rdata = bbm_view(q, avs.address);
      d.rd_done = 1'b1;
    end
    if (wr_ok) begin
      if (avs.address[7] == `BBM_GPR_TAG) begin
        d.gpr[avs.address[6:2]] = wdat[7:0];
      end else if (avs.address[7:5] == `BBM_IO_TAG) begin
        d.io[avs.address[4:2]] = wdat[7:0];
      end else begin
        case ({avs.address[7:2], 2'h0})
          `BBM_ADDR_CMD: begin
            d.op = bbm_pkg::bbm_op_e'(wdat[`BBM_CMD_OP]);
            d.rd = wdat[`BBM_CMD_RD];
            d.rr = wdat[`BBM_CMD_RR];
            d.bsel = wdat[`BBM_CMD_BIT];
            d.st = bbm_pkg::BBM_ST_EXEC;
          end
          `BBM_ADDR_OFFSET: d.koff = wdat[7:0];
          `BBM_ADDR_PC: d.pc = wdat[15:0];
          `BBM_ADDR_FLAGS: d.flags = wdat[7:0];
          default: d.koff = q.koff;
        endcase
      end
    end

    case (q.st)
      bbm_pkg::BBM_ST_IDLE: begin
        d.last_cyc = q.last_cyc;
      end
      bbm_pkg::BBM_ST_EXEC: begin
        d.pc = bbm_pc_next(q.pc, q.koff, 1'b0);
        d.last_cyc = `BBM_CYC_ONE;
        d.st = bbm_pkg::BBM_ST_IDLE;
        if (ev.is_branch) begin
          // Taken branches spend a second cycle [RL1] [RL2] [RL6] [RL8]
          d.pc = bbm_pc_next(q.pc, q.koff, ev.taken); // [RL1] [RL3] [RL19]
          if (ev.taken) begin
            d.last_cyc = `BBM_CYC_TWO;
            d.st = bbm_pkg::BBM_ST_HOLD;
          end
        end else if (ev.is_shift) begin
          d.gpr[q.rd] = ev.shifted; // [RL10] [RL11] [RL12] [RL13]
          d.flags = ev.shift_flags;
        end else begin
          case (q.op)
            bbm_pkg::BBM_OP_SET_IO_BIT,
            bbm_pkg::BBM_OP_CLEAR_IO_BIT: begin
              // Read-modify-write of one bit needs the extra cycle
              d.io[q.rr[2:0]] = bbm_put_bit(q.io[q.rr[2:0]], q.bsel,
                                  q.op == bbm_pkg::BBM_OP_SET_IO_BIT); // [RL9]
              d.last_cyc = `BBM_CYC_TWO;
              d.st = bbm_pkg::BBM_ST_HOLD;
            end
            bbm_pkg::BBM_OP_FLAG_SET,
            bbm_pkg::BBM_OP_FLAG_CLEAR: begin
              // Bit select names the flag, I included [RL14] [RL15]
              d.flags = bbm_put_bit(q.flags, q.bsel,
                                    q.op == bbm_pkg::BBM_OP_FLAG_SET);
            end
            bbm_pkg::BBM_OP_BIT_STORE_TRANSFER: begin
              d.flags[`BBM_FLAG_T] = src[q.bsel]; // [RL16]
            end
            bbm_pkg::BBM_OP_BIT_LOAD_TRANSFER: begin
              d.gpr[q.rd] = bbm_put_bit(opnd, q.bsel, q.flags[`BBM_FLAG_T]); // [RL17]
            end
            bbm_pkg::BBM_OP_COPY_REGISTER_BYTE: begin
              d.gpr[q.rd] = src; // [RL18]
            end
            bbm_pkg::BBM_OP_COPY_REGISTER_PAIR: begin
              // Pair indices are forced even, low byte first
              d.gpr[{q.rd[4:1], 1'b0}] = q.gpr[{q.rr[4:1], 1'b0}]; // [RL18]
              d.gpr[{q.rd[4:1], 1'b1}] = q.gpr[{q.rr[4:1], 1'b1}];
            end
            default: d.st = bbm_pkg::BBM_ST_IDLE;
          endcase
        end
      end
      bbm_pkg::BBM_ST_HOLD: begin
        d.st = bbm_pkg::BBM_ST_IDLE;
      end
      default: d.st = bbm_pkg::BBM_ST_IDLE;
    endcase
  end

  // Single state register
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q <= '0;
      q.st <= bbm_pkg::BBM_ST_IDLE;
      q.op <= bbm_pkg::BBM_OP_NOP;
      q.pc <= `BBM_PC_RESET;
      q.flags <= `BBM_FLAGS_RESET;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  chk_not_zero_target: assert property ( // [RL1]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_BRANCH_NOT_ZERO
    && !q.flags[`BBM_FLAG_Z]
    |=> q.pc == $past(q.pc) + {{8{$past(q.koff[7])}}, $past(q.koff)} + 16'h0001)
    else $error("not-zero branch target wrong");

  chk_carry_two_cycles: assert property ( // [RL2]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_BRANCH_CARRY_ONE
    && q.flags[`BBM_FLAG_C]
    |=> q.st == bbm_pkg::BBM_ST_HOLD ##1 q.st == bbm_pkg::BBM_ST_IDLE)
    else $error("taken carry branch not two cycles");

  chk_positive_fall: assert property ( // [RL3]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_BRANCH_POSITIVE
    && q.flags[`BBM_FLAG_N]
    |=> q.pc == $past(q.pc) + 16'h0001 && q.last_cyc == `BBM_CYC_ONE)
    else $error("untaken positive branch did not fall through");

  chk_signed_ge_taken: assert property ( // [RL4]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_BRANCH_SIGNED_GE
    |=> (q.last_cyc == `BBM_CYC_TWO)
        == !($past(q.flags[`BBM_FLAG_N]) ^ $past(q.flags[`BBM_FLAG_V])))
    else $error("signed ge decision wrong");

  chk_branch_flags: assert property ( // [RL7]
    q.st == bbm_pkg::BBM_ST_EXEC && ev.is_branch |=> $stable(q.flags))
    else $error("branch changed a flag");

  chk_io_bit_set: assert property ( // [RL9]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_SET_IO_BIT
    |=> q.io[$past(q.rr[2:0])][$past(q.bsel)] && $stable(q.flags)
        ##1 q.st == bbm_pkg::BBM_ST_IDLE)
    else $error("io bit set wrong");

  chk_shift_left: assert property ( // [RL10]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_LOGIC_SHIFT_LEFT
    |=> q.gpr[$past(q.rd)] == {$past(opnd[6:0]), 1'b0}
        && q.flags[`BBM_FLAG_C] == $past(opnd[7]))
    else $error("left shift result wrong");

  chk_flag_set_only: assert property ( // [RL14]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_FLAG_SET
    |=> q.flags == ($past(q.flags) | (8'h01 << $past(q.bsel))))
    else $error("flag set touched other flags");

  chk_bit_store: assert property ( // [RL16]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_BIT_STORE_TRANSFER
    |=> q.flags[`BBM_FLAG_T] == $past(src[q.bsel]))
    else $error("bit store into transfer flag wrong");

  chk_byte_copy: assert property ( // [RL18]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_COPY_REGISTER_BYTE
    |=> q.gpr[$past(q.rd)] == $past(src) && $stable(q.flags)
        && q.st == bbm_pkg::BBM_ST_IDLE)
    else $error("byte copy wrong");

  chk_not_zero_fall: assert property ( // [RL1]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_BRANCH_NOT_ZERO
    && q.flags[`BBM_FLAG_Z]
    |=> q.pc == $past(q.pc) + 16'h0001 && q.last_cyc == `BBM_CYC_ONE)
    else $error("not-zero branch taken with zero flag set");

  chk_lower_decision: assert property ( // [RL2]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_BRANCH_LOWER
    |=> (q.last_cyc == `BBM_CYC_TWO) == $past(q.flags[`BBM_FLAG_C]))
    else $error("lower branch decision wrong");

  chk_signed_lt_taken: assert property ( // [RL4]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_BRANCH_SIGNED_LT
    |=> (q.last_cyc == `BBM_CYC_TWO)
        == ($past(q.flags[`BBM_FLAG_N]) ^ $past(q.flags[`BBM_FLAG_V])))
    else $error("signed lt decision wrong");

  chk_half_carry_taken: assert property ( // [RL5]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_BRANCH_HALF_CARRY_ONE
    |=> (q.last_cyc == `BBM_CYC_TWO) == $past(q.flags[`BBM_FLAG_H]))
    else $error("half-carry branch decision wrong");

  chk_transfer_two_cycles: assert property ( // [RL6]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_BRANCH_TRANSFER_ZERO
    && !q.flags[`BBM_FLAG_T]
    |=> q.st == bbm_pkg::BBM_ST_HOLD ##1 q.st == bbm_pkg::BBM_ST_IDLE)
    else $error("taken transfer branch not two cycles");

  chk_irq_fall: assert property ( // [RL8]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_BRANCH_IRQ_ENABLED
    && !q.flags[`BBM_FLAG_I]
    |=> q.st == bbm_pkg::BBM_ST_IDLE && q.last_cyc == `BBM_CYC_ONE)
    else $error("untaken interrupt branch not one cycle");

  chk_io_bit_clear: assert property ( // [RL9]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_CLEAR_IO_BIT
    |=> !q.io[$past(q.rr[2:0])][$past(q.bsel)] && $stable(q.flags)
        ##1 q.st == bbm_pkg::BBM_ST_IDLE)
    else $error("io bit clear wrong");

  chk_shift_right: assert property ( // [RL11]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_LOGIC_SHIFT_RIGHT
    |=> q.gpr[$past(q.rd)] == {1'b0, $past(opnd[7:1])}
        && q.flags[`BBM_FLAG_C] == $past(opnd[0]))
    else $error("right shift result wrong");

  chk_rotate_carry: assert property ( // [RL12]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_ROTATE_LEFT_CARRY
    |=> q.gpr[$past(q.rd)] == {$past(opnd[6:0]), $past(q.flags[`BBM_FLAG_C])}
        && q.flags[`BBM_FLAG_C] == $past(opnd[7]))
    else $error("rotate through carry wrong");

  chk_arith_sign: assert property ( // [RL13]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_ARITH_SHIFT_RIGHT
    |=> q.gpr[$past(q.rd)] == {$past(opnd[7]), $past(opnd[7:1])}
        && q.flags[`BBM_FLAG_C] == $past(opnd[0]))
    else $error("arithmetic right shift wrong");

  chk_bit_load: assert property ( // [RL17]
    q.st == bbm_pkg::BBM_ST_EXEC && q.op == bbm_pkg::BBM_OP_BIT_LOAD_TRANSFER
    |=> q.gpr[$past(q.rd)][$past(q.bsel)] == $past(q.flags[`BBM_FLAG_T])
        && $stable(q.flags))
    else $error("bit load from transfer flag wrong");

endmodule : bbm_core

//--- bbm_consts.svh
`ifndef BBM_CONSTS_SVH
`define BBM_CONSTS_SVH

// Status flag bit positions
`define BBM_FLAG_C 0
`define BBM_FLAG_Z 1
`define BBM_FLAG_N 2
`define BBM_FLAG_V 3
`define BBM_FLAG_S 4
`define BBM_FLAG_H 5
`define BBM_FLAG_T 6
`define BBM_FLAG_I 7

// Register byte offsets and regions
`define BBM_ADDR_CMD 8'h00
`define BBM_ADDR_OFFSET 8'h04
`define BBM_ADDR_PC 8'h08
`define BBM_ADDR_FLAGS 8'h0c
`define BBM_ADDR_STATUS 8'h10
`define BBM_IO_TAG 3'h2
`define BBM_GPR_TAG 1'h1

// Command word fields
`define BBM_CMD_OP 5:0
`define BBM_CMD_RD 12:8
`define BBM_CMD_RR 20:16
`define BBM_CMD_BIT 26:24

// Reset values and cycle counts
`define BBM_PC_RESET 16'h0000
`define BBM_FLAGS_RESET 8'h00
`define BBM_CYC_ONE 2'h1
`define BBM_CYC_TWO 2'h2

`endif

//--- bbm_pkg.sv
package bbm_pkg;

  typedef enum logic [2:0] {
    BBM_ST_IDLE = 3'h1,
    BBM_ST_EXEC = 3'h2,
    BBM_ST_HOLD = 3'h4
  } bbm_state_e;

  typedef enum logic [5:0] {
    BBM_OP_NOP = 6'h00,
    BBM_OP_BRANCH_NOT_ZERO = 6'h01,
    BBM_OP_BRANCH_CARRY_ONE = 6'h02,
    BBM_OP_BRANCH_CARRY_ZERO = 6'h03,
    BBM_OP_BRANCH_SAME_OR_HIGHER = 6'h04,
    BBM_OP_BRANCH_LOWER = 6'h05,
    BBM_OP_BRANCH_NEGATIVE = 6'h06,
    BBM_OP_BRANCH_POSITIVE = 6'h07,
    BBM_OP_BRANCH_SIGNED_GE = 6'h08,
    BBM_OP_BRANCH_SIGNED_LT = 6'h09,
    BBM_OP_BRANCH_HALF_CARRY_ONE = 6'h0a,
    BBM_OP_BRANCH_HALF_CARRY_ZERO = 6'h0b,
    BBM_OP_BRANCH_TRANSFER_ONE = 6'h0c,
    BBM_OP_BRANCH_TRANSFER_ZERO = 6'h0d,
    BBM_OP_BRANCH_OVERFLOW_ONE = 6'h0e,
    BBM_OP_BRANCH_OVERFLOW_ZERO = 6'h0f,
    BBM_OP_BRANCH_IRQ_ENABLED = 6'h10,
    BBM_OP_BRANCH_IRQ_DISABLED = 6'h11,
    BBM_OP_SET_IO_BIT = 6'h12,
    BBM_OP_CLEAR_IO_BIT = 6'h13,
    BBM_OP_LOGIC_SHIFT_LEFT = 6'h14,
    BBM_OP_LOGIC_SHIFT_RIGHT = 6'h15,
    BBM_OP_ROTATE_LEFT_CARRY = 6'h16,
    BBM_OP_ARITH_SHIFT_RIGHT = 6'h17,
    BBM_OP_FLAG_SET = 6'h18,
    BBM_OP_FLAG_CLEAR = 6'h19,
    BBM_OP_BIT_STORE_TRANSFER = 6'h1a,
    BBM_OP_BIT_LOAD_TRANSFER = 6'h1b,
    BBM_OP_COPY_REGISTER_BYTE = 6'h1c,
    BBM_OP_COPY_REGISTER_PAIR = 6'h1d
  } bbm_op_e;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } bbm_avs_req_s;

  // Branch condition and shift result
  typedef struct packed {
    logic is_branch;
    logic taken;
    logic is_shift;
    logic [7:0] shifted;
    logic [7:0] shift_flags;
  } bbm_eval_s;

  typedef struct packed {
    bbm_state_e st;
    bbm_op_e op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bsel;
    logic [7:0] koff;
    logic [15:0] pc;
    logic [7:0] flags;
    logic [1:0] last_cyc;
    logic rd_done;
    logic [31:0] rdata;
    logic [7:0][7:0] io;
    logic [31:0][7:0] gpr;
  } bbm_core_s;

endpackage : bbm_pkg

//--- bbm_eval.sv
`include "bbm_consts.svh"

module bbm_eval (
  input wire bbm_pkg::bbm_op_e op,
  input wire logic [7:0] flags,
  input wire logic [7:0] opnd,
  output bbm_pkg::bbm_eval_s ev
);

  logic carry;
  logic [7:0] res;

  // Branch conditions; flags themselves are never touched by a branch
  always_comb begin
    ev = '0;
    ev.is_branch = 1'b1;
    case (op)
      bbm_pkg::BBM_OP_BRANCH_NOT_ZERO: ev.taken = !flags[`BBM_FLAG_Z]; // [RL1]
      bbm_pkg::BBM_OP_BRANCH_CARRY_ONE,
      bbm_pkg::BBM_OP_BRANCH_LOWER: ev.taken = flags[`BBM_FLAG_C]; // [RL2]
      bbm_pkg::BBM_OP_BRANCH_CARRY_ZERO,
      bbm_pkg::BBM_OP_BRANCH_SAME_OR_HIGHER: ev.taken = !flags[`BBM_FLAG_C]; // [RL2]
      bbm_pkg::BBM_OP_BRANCH_NEGATIVE: ev.taken = flags[`BBM_FLAG_N]; // [RL3]
      bbm_pkg::BBM_OP_BRANCH_POSITIVE: ev.taken = !flags[`BBM_FLAG_N]; // [RL3]
      bbm_pkg::BBM_OP_BRANCH_SIGNED_GE:
        ev.taken = !(flags[`BBM_FLAG_N] ^ flags[`BBM_FLAG_V]); // [RL4]
      bbm_pkg::BBM_OP_BRANCH_SIGNED_LT:
        ev.taken = flags[`BBM_FLAG_N] ^ flags[`BBM_FLAG_V]; // [RL4]
      bbm_pkg::BBM_OP_BRANCH_HALF_CARRY_ONE: ev.taken = flags[`BBM_FLAG_H]; // [RL5]
      bbm_pkg::BBM_OP_BRANCH_HALF_CARRY_ZERO: ev.taken = !flags[`BBM_FLAG_H]; // [RL5]
      bbm_pkg::BBM_OP_BRANCH_TRANSFER_ONE: ev.taken = flags[`BBM_FLAG_T]; // [RL6]
      bbm_pkg::BBM_OP_BRANCH_TRANSFER_ZERO: ev.taken = !flags[`BBM_FLAG_T]; // [RL6]
      bbm_pkg::BBM_OP_BRANCH_OVERFLOW_ONE: ev.taken = flags[`BBM_FLAG_V]; // [RL7]
      bbm_pkg::BBM_OP_BRANCH_OVERFLOW_ZERO: ev.taken = !flags[`BBM_FLAG_V]; // [RL7]
      bbm_pkg::BBM_OP_BRANCH_IRQ_ENABLED: ev.taken = flags[`BBM_FLAG_I]; // [RL8]
      bbm_pkg::BBM_OP_BRANCH_IRQ_DISABLED: ev.taken = !flags[`BBM_FLAG_I]; // [RL8]
      default: ev.is_branch = 1'b0;
    endcase

    // Shifts; S is left alone since only Z, C, N and V change
    carry = 1'b0;
    res = opnd;
    ev.is_shift = 1'b1;
    case (op)
      bbm_pkg::BBM_OP_LOGIC_SHIFT_LEFT: begin
        res = {opnd[6:0], 1'b0}; // [RL10]
        carry = opnd[7];
      end
      bbm_pkg::BBM_OP_LOGIC_SHIFT_RIGHT: begin
        res = {1'b0, opnd[7:1]}; // [RL11]
        carry = opnd[0];
      end
      bbm_pkg::BBM_OP_ROTATE_LEFT_CARRY: begin
        res = {opnd[6:0], flags[`BBM_FLAG_C]}; // [RL12]
        carry = opnd[7];
      end
      bbm_pkg::BBM_OP_ARITH_SHIFT_RIGHT: begin
        res = {opnd[7], opnd[7:1]}; // [RL13]
        carry = opnd[0];
      end
      default: ev.is_shift = 1'b0;
    endcase
    ev.shifted = res;
    ev.shift_flags = flags;
    ev.shift_flags[`BBM_FLAG_C] = carry;
    ev.shift_flags[`BBM_FLAG_Z] = (res == 8'h00);
    ev.shift_flags[`BBM_FLAG_N] = res[7];
    ev.shift_flags[`BBM_FLAG_V] = res[7] ^ carry; // Overflow follows N xor C
  end

endmodule : bbm_eval

//--- testbench.sv
`include "bbm_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk;
  logic rst_n;
  bbm_pkg::bbm_avs_req_s avs;
  logic [31:0] readdata;
  logic waitrequest;
  logic busy;
  logic [15:0] pc;
  logic [7:0][7:0] io_regs;
  int err_total;
  int cmp_count;
  int last_waits;
  logic [31:0] rv;

  bbm_core dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .avs(avs),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .busy(busy),
    .pc(pc),
    .io_regs(io_regs)
  );

  // Free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out();
    $display("Comparisons: %0d, mismatches: %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // One Avalon transfer; the request stands until waitrequest is low at a rising edge.
  // Levels are looked at mid-cycle, since inputs only move just after rising edges.
  task automatic bus_xfer(input logic rd, input logic [7:0] a, input logic [31:0] d);
    last_waits = 0;
    avs.read <= rd;
    avs.write <= ~rd;
    avs.address <= a;
    avs.writedata <= d;
    @(negedge clk);
    while (waitrequest !== 1'b0) begin
      last_waits++;
      @(negedge clk);
    end
    rv = readdata;
    @(posedge clk);
    avs.read <= 1'b0;
    avs.write <= 1'b0;
  endtask : bus_xfer

  // Lets an edge pass after release so no signal is driven twice in one step
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    bus_xfer(1'b0, a, d);
    @(posedge clk);
  endtask : bus_wr

  task automatic rd_chk(input string w, input logic [7:0] a, input logic [31:0] e);
    bus_xfer(1'b1, a, 32'h0);
    @(posedge clk);
    chk(w, e, rv);
  endtask : rd_chk

  // Counts the cycles busy stands, bounded so a stuck busy cannot hang the run
  task automatic wait_idle(output int n);
    n = 0;
    @(negedge clk);
    while (busy === 1'b1 && n < 50) begin
      n++;
      @(negedge clk);
    end
    @(posedge clk);
  endtask : wait_idle

  task automatic run_op(input logic [5:0] op, input logic [4:0] rd, input logic [4:0] rr,
      input logic [2:0] b, input int cyc);
    int n;
    bus_xfer(1'b0, `BBM_ADDR_CMD, {5'h0, b, 3'h0, rr, 3'h0, rd, 2'h0, op});
    wait_idle(n);
    chk("cycle count", cyc, n);
  endtask : run_op

  function automatic logic br_cond(input logic [5:0] op, input logic [7:0] f);
    case (op)
      6'h01: br_cond = !f[`BBM_FLAG_Z];
      6'h02, 6'h05: br_cond = f[`BBM_FLAG_C];
      6'h03, 6'h04: br_cond = !f[`BBM_FLAG_C];
      6'h06: br_cond = f[`BBM_FLAG_N];
      6'h07: br_cond = !f[`BBM_FLAG_N];
      6'h08: br_cond = !(f[`BBM_FLAG_N] ^ f[`BBM_FLAG_V]);
      6'h09: br_cond = f[`BBM_FLAG_N] ^ f[`BBM_FLAG_V];
      6'h0a: br_cond = f[`BBM_FLAG_H];
      6'h0b: br_cond = !f[`BBM_FLAG_H];
      6'h0c: br_cond = f[`BBM_FLAG_T];
      6'h0d: br_cond = !f[`BBM_FLAG_T];
      6'h0e: br_cond = f[`BBM_FLAG_V];
      6'h0f: br_cond = !f[`BBM_FLAG_V];
      6'h10: br_cond = f[`BBM_FLAG_I];
      6'h11: br_cond = !f[`BBM_FLAG_I];
      default: br_cond = 1'b0;
    endcase
  endfunction : br_cond

  // Every branch against all-clear, all-set and N without V, both offset signs
  task automatic t_branches();
    logic [7:0] fl;
    logic tk;
    for (int op = 1; op <= 17; op++) begin
      for (int p = 0; p < 3; p++) begin
        fl = (p == 0) ? 8'h00 : (p == 1) ? 8'hff : 8'h04;
        tk = br_cond(op[5:0], fl);
        bus_wr(`BBM_ADDR_PC, 32'h0000_0100);
        bus_wr(`BBM_ADDR_OFFSET, {24'h0, (p == 1) ? 8'h7f : 8'h80});
        bus_wr(`BBM_ADDR_FLAGS, {24'h0, fl});
        run_op(op[5:0], 5'h0, 5'h0, 3'h0, tk ? 2 : 1);
        chk("branch pc", tk ? ((p == 1) ? 32'h180 : 32'h081) : 32'h101, {16'h0, pc});
        rd_chk("branch flags", `BBM_ADDR_FLAGS, {24'h0, fl});
      end
    end
  endtask : t_branches

  // Io bit set and clear, then two back to back so the second must stall
  task automatic t_io_bits();
    int n;
    bus_wr(8'h48, 32'ha5);
    bus_wr(8'h4c, 32'h5a);
    bus_wr(`BBM_ADDR_FLAGS, 32'ha5);
    run_op(6'h12, 5'h0, 5'h3, 3'h0, 2);
    chk("io set", 32'h5b, {24'h0, io_regs[3]});
    run_op(6'h13, 5'h0, 5'h3, 3'h6, 2);
    chk("io clear", 32'h1b, {24'h0, io_regs[3]});
    bus_wr(`BBM_ADDR_CMD, {5'h0, 3'h7, 3'h0, 5'h3, 16'h0012});
    bus_wr(`BBM_ADDR_CMD, {5'h0, 3'h5, 3'h0, 5'h3, 16'h0012});
    chk("stall waits", 32'h1, last_waits);
    wait_idle(n);
    chk("io pair", 32'hbb, {24'h0, io_regs[3]});
    rd_chk("io status", `BBM_ADDR_STATUS, 32'h2);
    chk("io other", 32'ha5, {24'h0, io_regs[2]});
    rd_chk("io flags", `BBM_ADDR_FLAGS, 32'ha5);
  endtask : t_io_bits

  // Shifts over a table of values, carry in set, S and H preset to show they hold
  task automatic t_shifts();
    logic [7:0] v;
    logic [7:0] r;
    logic c;
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h81 : (i == 1) ? 8'h40 : 8'h00;
      for (int op = 6'h14; op <= 6'h17; op++) begin
        case (op)
          6'h14: {c, r} = {v, 1'b0};
          6'h15: {r, c} = {1'b0, v};
          6'h16: {c, r} = {v, 1'b1};
          default: {r, c} = {v[7], v};
        endcase
        bus_wr(8'h94, {24'h0, v});
        bus_wr(`BBM_ADDR_FLAGS, 32'h31);
        run_op(op[5:0], 5'h5, 5'h0, 3'h0, 1);
        rd_chk("shift result", 8'h94, {24'h0, r});
        rd_chk("shift flags", `BBM_ADDR_FLAGS,
          {24'h0, 4'h3, r[7] ^ c, r[7], r == 8'h00, c});
      end
    end
  endtask : t_shifts

  // Each flag forced alone, from all-clear and from all-set
  task automatic t_flags();
    for (int b = 0; b < 8; b++) begin
      bus_wr(`BBM_ADDR_FLAGS, 32'h00);
      run_op(6'h18, 5'h0, 5'h0, b[2:0], 1);
      rd_chk("flag set", `BBM_ADDR_FLAGS, 32'h1 << b);
      bus_wr(`BBM_ADDR_FLAGS, 32'hff);
      run_op(6'h19, 5'h0, 5'h0, b[2:0], 1);
      rd_chk("flag clear", `BBM_ADDR_FLAGS, {24'h0, ~(8'h1 << b)});
    end
  endtask : t_flags

  // Transfer bit store and load, then byte and pair copies
  task automatic t_moves();
    bus_wr(8'h9c, 32'h20);
    bus_wr(8'ha4, 32'h00);
    bus_wr(`BBM_ADDR_FLAGS, 32'hbf);
    run_op(6'h1a, 5'h0, 5'h7, 3'h5, 1);
    rd_chk("store one", `BBM_ADDR_FLAGS, 32'hff);
    run_op(6'h1b, 5'h9, 5'h0, 3'h3, 1);
    rd_chk("load bit", 8'ha4, 32'h08);
    rd_chk("load flags", `BBM_ADDR_FLAGS, 32'hff);
    run_op(6'h1a, 5'h0, 5'h7, 3'h4, 1);
    rd_chk("store zero", `BBM_ADDR_FLAGS, 32'hbf);
    bus_wr(8'ha8, 32'h3c);
    bus_wr(8'hd0, 32'h11);
    bus_wr(8'hd4, 32'h22);
    bus_wr(`BBM_ADDR_FLAGS, 32'h5a);
    run_op(6'h1c, 5'hc, 5'ha, 3'h0, 1);
    rd_chk("copy byte", 8'hb0, 32'h3c);
    run_op(6'h1d, 5'he, 5'h14, 3'h0, 1);
    rd_chk("copy low", 8'hb8, 32'h11);
    rd_chk("copy high", 8'hbc, 32'h22);
    rd_chk("copy flags", `BBM_ADDR_FLAGS, 32'h5a);
  endtask : t_moves

  // Watchdog well beyond the thousand or so cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end

  // Reset pc, io and flags, unmapped access, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    avs = '0;
    avs.byteenable = 4'hf;
    err_total = 0;
    cmp_count = 0;
    last_waits = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("reset pc", 32'h0, {16'h0, pc});
    chk("reset io", 32'h0, {24'h0, io_regs[3]});
    rd_chk("reset flags", `BBM_ADDR_FLAGS, 32'h0);
    bus_wr(8'h20, 32'h77);
    rd_chk("unmapped", 8'h20, 32'h0);
    t_branches();
    t_io_bits();
    t_shifts();
    t_flags();
    t_moves();
    close_out();
  end

endmodule : testbench
